// ===== hw/adc_ctrl_defines.vh
// constants shared by the converter control block and its result buffer
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// =====================================================================
// result format
`define RES_BITS 16
`define RES_MSB_WEIGHT 16'h8000
`define RES_RESET_VALUE 16'h0000

// =====================================================================
// acquisition timing, in conversion clock falling edges
// edges that must have passed since the end of a conversion for an
// immediate start; the start edge itself is then the fourth
`define ACQ_PASSED_EDGES 2'h3
`define ACQ_CNT_BITS 2

// =====================================================================
// result buffer
`define RESULT_FIFO_DEPTH 16
`define RESULT_FIFO_AW 4

// =====================================================================
// synchroniser input positions
`define SYN_CONVERT_START_N_CLK 0
`define SYN_SCLK 1
`define SYN_CS_N 2
`define SYN_START_N 3
`define SYN_CMP 4
`define SYN_COUNT 5

// =====================================================================
// conversion states
`define ST_IDLE 1'b0
`define ST_CONVERT_START_N 1'b1

`endif

// ===== hw/result_fifo.v
// first-in first-out buffer for finished conversion results
`include "adc_ctrl_defines.vh"

module result_fifo #(
    parameter WIDTH = `RES_BITS,
    parameter DEPTH = `RESULT_FIFO_DEPTH,
    parameter AW = `RESULT_FIFO_AW
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // filling side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;

    // full and empty come straight from the occupancy count
    assign in_ready_o = (count_ff != DEPTH[AW:0]);
    assign out_valid_o = (count_ff != {(AW+1){1'b0}});
    assign out_data_o = mem_ff[rd_ptr_ff];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // storage has no reset; only the pointers and the count carry control state
    always @(posedge mclk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                             : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                             : rd_ptr_ff + 1'b1;
            end
            if (push & ~pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop & ~push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule

// ===== hw/adc_result_readout_and_start.v
// converter control: acquisition-timed start, bit search and serial readout
//
// What this block does
// - with chip select high between conversions the msb is on the data output, once cs falls, before any sclk.
// - each sclk pulse moves the output to the next lower bit; the 15th shows the lsb.
// - after the lsb every further sclk pulse puts a zero on the output.
// - the output bit changes only on a falling sclk edge.
// - at least four conversion clock periods of acquisition separate two conversions.
// - after more than three cycles idle, conversion starts on the next falling clock edge.
// - a start request made earlier waits for the fourth falling edge after the last end.
// - conversions start one by one from the start input or run back to back via done.
// - the data output is driven only while chip select is low, otherwise high impedance.
// - start requests during a conversion are ignored.
`include "adc_ctrl_defines.vh"

module adc_result_readout_and_start #(
    parameter RES_W = `RES_BITS,
    parameter FIFO_DEPTH = `RESULT_FIFO_DEPTH,
    parameter FIFO_AW = `RESULT_FIFO_AW
) (
    // system clock and reset
    input wire mclk_i,
    input wire rst_i,
    // conversion clock and start, from the host
    input wire convert_start_n_clk_i,
    input wire convert_start_n_i,
    output wire convert_start_n_done_n_o,
    // serial readout pins
    input wire sclk_i,
    input wire cs_n_i,
    output wire dout_o,
    output wire dout_oe_o,
    // analog front end: trial code out, comparator decision back
    output wire [RES_W-1:0] dac_code_o,
    input wire cmp_high_i,
    output wire track_o
);

    // =================================================================
    // pin synchronisers
    // every pin comes from outside mclk; two flops each, and a third
    // flop per pin only for edge detection off the second stage
    reg [`SYN_COUNT-1:0] syn1_ff;
    reg [`SYN_COUNT-1:0] syn2_ff;
    reg [`SYN_COUNT-1:0] syn3_ff;
    wire [`SYN_COUNT-1:0] pin_raw;

    assign pin_raw = {cmp_high_i, convert_start_n_i, cs_n_i, sclk_i, convert_start_n_clk_i};

    genvar gi;
    generate
        for (gi = 0; gi < `SYN_COUNT; gi = gi + 1) begin : g_sync
            // idle levels after reset: clocks low, strobes inactive high
            always @(posedge mclk_i) begin
                if (rst_i) begin
                    syn1_ff[gi] <= (gi == `SYN_CS_N || gi == `SYN_START_N);
                    syn2_ff[gi] <= (gi == `SYN_CS_N || gi == `SYN_START_N);
                    syn3_ff[gi] <= (gi == `SYN_CS_N || gi == `SYN_START_N);
                end else begin
                    syn1_ff[gi] <= pin_raw[gi];
                    syn2_ff[gi] <= syn1_ff[gi];
                    syn3_ff[gi] <= syn2_ff[gi];
                end
            end
        end
    endgenerate

    wire convert_start_n_fall;
    wire sclk_fall;
    wire cs_low;
    wire start_low;
    wire cmp_high;

    assign convert_start_n_fall = syn3_ff[`SYN_CONVERT_START_N_CLK] & ~syn2_ff[`SYN_CONVERT_START_N_CLK];
    assign sclk_fall = syn3_ff[`SYN_SCLK] & ~syn2_ff[`SYN_SCLK];
    assign cs_low = ~syn2_ff[`SYN_CS_N];
    assign start_low = ~syn2_ff[`SYN_START_N];
    assign cmp_high = syn2_ff[`SYN_CMP];

    // =================================================================
    // result buffer between the bit search and the readout register
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [RES_W-1:0] fifo_out_data;
    reg push_ff;
    reg [RES_W-1:0] result_ff;

    result_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(push_ff),
        .in_ready_o(fifo_in_ready),
        .in_data_i(result_ff),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // =================================================================
    // start request and acquisition counting
    reg state_ff;
    reg pending_ff;
    reg [`ACQ_CNT_BITS-1:0] acq_cnt_ff;
    reg acq_done_ff;
    wire acq_ok;
    wire begin_convert_start_n;

    // enough edges since the last end: either counted out or never converted
    assign acq_ok = acq_done_ff | (acq_cnt_ff == `ACQ_PASSED_EDGES);

    // a full buffer stalls the start so no result is ever dropped
    assign begin_convert_start_n = (state_ff == `ST_IDLE) & convert_start_n_fall & acq_ok
                        & (pending_ff | start_low) & fifo_in_ready;

    // a low start level is remembered while idle; in conversion it is dropped
    always @(posedge mclk_i) begin
        if (rst_i) begin
            pending_ff <= 1'b0;
        end else if (state_ff == `ST_CONVERT_START_N) begin
            pending_ff <= 1'b0;
        end else if (begin_convert_start_n) begin
            pending_ff <= 1'b0;
        end else if (start_low) begin
            pending_ff <= 1'b1;
        end
    end

    // falling conversion clock edges counted from the end of a conversion,
    // saturating once three have passed so the next one may start at once
    always @(posedge mclk_i) begin
        if (rst_i) begin
            acq_cnt_ff <= {`ACQ_CNT_BITS{1'b0}};
            acq_done_ff <= 1'b1;
        end else if (push_ff) begin
            acq_cnt_ff <= {`ACQ_CNT_BITS{1'b0}};
            acq_done_ff <= 1'b0;
        end else if ((state_ff == `ST_IDLE) & convert_start_n_fall & ~acq_ok) begin
            acq_cnt_ff <= acq_cnt_ff + 1'b1;
        end else if ((state_ff == `ST_IDLE) & acq_ok) begin
            acq_done_ff <= 1'b1;
        end
    end

    // =================================================================
    // successive approximation over the conversion clock
    reg [RES_W-1:0] trial_ff;
    reg [RES_W-1:0] bit_ff;
    reg done_n_ff;
    reg first_ff;
    wire [RES_W-1:0] decided;

    // keep the trial bit when the input is at or above the trial level
    assign decided = cmp_high ? trial_ff : (trial_ff & ~bit_ff);

    // the start edge ends acquisition; the next edge raises done and the
    // sixteen edges after the start decide msb down to lsb
    always @(posedge mclk_i) begin
        if (rst_i) begin
            state_ff <= `ST_IDLE;
            trial_ff <= `RES_RESET_VALUE;
            bit_ff <= `RES_RESET_VALUE;
            done_n_ff <= 1'b0;
            first_ff <= 1'b0;
            push_ff <= 1'b0;
            result_ff <= `RES_RESET_VALUE;
        end else begin
            push_ff <= 1'b0;
            case (state_ff)
                `ST_IDLE: begin
                    if (begin_convert_start_n) begin
                        state_ff <= `ST_CONVERT_START_N;
                        trial_ff <= `RES_MSB_WEIGHT;
                        bit_ff <= `RES_MSB_WEIGHT;
                        first_ff <= 1'b1;
                    end
                end
                `ST_CONVERT_START_N: begin
                    if (convert_start_n_fall) begin
                        if (first_ff) begin
                            done_n_ff <= 1'b1;
                            first_ff <= 1'b0;
                        end
                        if (bit_ff == {{(RES_W-1){1'b0}}, 1'b1}) begin
                            // lsb decided: hand the word on and open acquisition
                            result_ff <= decided;
                            push_ff <= 1'b1;
                            done_n_ff <= 1'b0;
                            state_ff <= `ST_IDLE;
                            trial_ff <= decided;
                        end else begin
                            trial_ff <= decided | (bit_ff >> 1);
                            bit_ff <= bit_ff >> 1;
                        end
                    end
                end
                default: begin
                    state_ff <= `ST_IDLE;
                end
            endcase
        end
    end

    assign convert_start_n_done_n_o = done_n_ff;
    assign dac_code_o = trial_ff;
    assign track_o = (state_ff == `ST_IDLE);

    // =================================================================
    // serial readout
    reg [RES_W-1:0] hold_ff;
    reg [RES_W-1:0] shift_ff;
    reg oe_ff;

    // the buffer is drained only while chip select is high, so a read in
    // progress never sees its word replaced; holding cs low lets it fill
    assign fifo_out_ready = ~cs_low;

    // hold keeps the last finished word so a repeated read starts again
    // at the msb; the shift copy is reloaded whenever cs is high
    always @(posedge mclk_i) begin
        if (rst_i) begin
            hold_ff <= `RES_RESET_VALUE;
            shift_ff <= `RES_RESET_VALUE;
        end else if (~cs_low) begin
            if (fifo_out_valid) begin
                hold_ff <= fifo_out_data;
                shift_ff <= fifo_out_data;
            end else begin
                shift_ff <= hold_ff;
            end
        end else if (sclk_fall) begin
            shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
        end
    end

    // the enable follows synchronised chip select
    always @(posedge mclk_i) begin
        if (rst_i) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= cs_low;
        end
    end

    assign dout_o = oe_ff & shift_ff[RES_W-1];
    assign dout_oe_o = oe_ff;

endmodule

// ===== sim/adc_ctrl_chk.sv
// concurrent checks on the converter control block ports
module adc_ctrl_chk (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // conversion pins
    input wire logic convert_start_n_clk_i,
    input wire logic convert_start_n_i,
    input wire logic convert_start_n_done_n_o,
    input wire logic track_o,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic dout_o,
    input wire logic dout_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cclk_ff;
    logic [4:0] run_ff;
    logic [3:0] acq_ff;
    logic [2:0] age_ff;
    wire logic fall = cclk_ff & ~convert_start_n_clk_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ====================================================================
    // helper counters
    // acq_ff and age_ff saturate and run_ff is held at zero while idle, so long idle spans never wrap round into false alarms
    always_ff @(posedge mclk_i) begin
        cclk_ff <= convert_start_n_clk_i;
        if (rst_i) begin
            run_ff <= 5'h00;
            acq_ff <= 4'hF;
            age_ff <= 3'h7;
        end else begin
            run_ff <= track_o ? 5'h00 : run_ff + {4'h0, fall};
            acq_ff <= !track_o ? 4'h0 : acq_ff + {3'h0, fall && acq_ff != 4'hF};
            age_ff <= $fell(sclk_i) ? 3'h1 : age_ff + {2'h0, age_ff != 3'h7};
        end
    end
    // ====================================================================
    // assertions
    oe_on_a: assert property ((!cs_n_i) [*5] |-> dout_oe_o)
        else $error("data output not enabled");
    oe_off_a: assert property (cs_n_i [*5] |-> !dout_oe_o)
        else $error("data output still enabled");
    dout_quiet_a: assert property (!dout_oe_o |-> !dout_o)
        else $error("data driven while disabled");
    shift_edge_a: assert property (
        dout_oe_o && $past(dout_oe_o) && $changed(dout_o) |-> age_ff inside {[3'h1:3'h5]})
        else $error("data changed away from a serial clock fall");
    done_rise_a: assert property ($rose(convert_start_n_done_n_o) |-> run_ff == 5'h01)
        else $error("done rose on the wrong clock fall");
    convert_start_n_len_a: assert property (
        $fell(convert_start_n_done_n_o) |-> run_ff inside {5'h10, 5'h11})
        else $error("conversion length wrong");
    acq_min_a: assert property ($fell(track_o) |-> acq_ff >= 4'h4)
        else $error("acquisition cut short");
    start_now_a: assert property (
        (!convert_start_n_i) [*4] ##0 (track_o && fall && acq_ff >= 4'h3) |-> ##[1:5] !track_o)
        else $error("conversion start missed");
    // ====================================================================
    // main scenarios reached
    cover property ($fell(convert_start_n_done_n_o));
    cover property ($fell(track_o) && acq_ff == 4'h4);
    cover property ($fell(sclk_i) && dout_oe_o);
endmodule

bind adc_result_readout_and_start adc_ctrl_chk u_chk (.mclk_i, .rst_i, .convert_start_n_clk_i,
    .convert_start_n_i, .convert_start_n_done_n_o, .track_o, .sclk_i, .cs_n_i, .dout_o, .dout_oe_o);

// ===== sim/host_model.sv
// host processor model: conversion clock, start, chip select and serial clock
module host_model (
    // pins seen by the host
    input wire logic dout_pin,
    input wire logic convert_start_n_done_n,
    // pins driven by the host
    output logic convert_start_n_clk,
    output logic start_n,
    output logic cs_n,
    output logic sclk
);
    timeunit 1ns;
    timeprecision 1ns;
    event got;
    logic [19:0] word;
    // ====================================================================
    // free-running conversion clock, 600 ns; serial clock idles low
    initial begin
        start_n = 1'b1;
        cs_n = 1'b1;
        sclk = 1'b0;
        convert_start_n_clk = 1'b0;
        forever #300 convert_start_n_clk = ~convert_start_n_clk;
    end
    // start launched just after a rising conversion clock edge
    task automatic start(input int periods);
        @(posedge convert_start_n_clk);
        #5 start_n = 1'b0;
        repeat (periods) @(posedge convert_start_n_clk);
        #5 start_n = 1'b1;
    endtask
    // polls done through one whole conversion, giving up after a bound
    task automatic wait_done(output logic ok);
        int i, j;
        for (i = 0; i < 400 && convert_start_n_done_n !== 1'b1; i++) #50;
        for (j = 0; j < 400 && convert_start_n_done_n !== 1'b0; j++) #50;
        ok = (i < 400) && (j < 400);
    endtask
    // twenty bits: the msb before any pulse, then one capture per rising edge
    task automatic read();
        @(posedge convert_start_n_clk) #12 cs_n = 1'b0;
        #600;
        for (int k = 19; k >= 0; k--) begin
            #200 sclk = 1'b1;
            word[k] = dout_pin;
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        ->got;
        #1000;
    endtask
endmodule

// ===== sim/adc_result_readout_and_start_test.sv
// self-checking bench for the converter control block
module adc_result_readout_and_start_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i, rst_i, cont, ok;
    logic [15:0] vin;
    logic [31:0] lfsr;
    logic [19:0] exp_q[$];
    int n_fail, checks_done;
    wire cclk, hst_n, cs_n, sclk, done_n, dout, oe, track, cmp;
    wire [15:0] dac;
    // the data pin floats whenever the block does not drive it
    wire dout_pin = oe ? dout : 1'bz;
    // comparator model: high while the input is at or above the trial code
    assign #2 cmp = vin >= dac;
    adc_result_readout_and_start uut (.mclk_i(mclk_i), .rst_i(rst_i), .convert_start_n_clk_i(cclk),
        .convert_start_n_i(cont ? done_n : hst_n), .convert_start_n_done_n_o(done_n), .sclk_i(sclk),
        .cs_n_i(cs_n), .dout_o(dout), .dout_oe_o(oe), .dac_code_o(dac), .cmp_high_i(cmp),
        .track_o(track));
    host_model u_host (.dout_pin(dout_pin), .convert_start_n_done_n(done_n), .convert_start_n_clk(cclk),
        .start_n(hst_n), .cs_n(cs_n), .sclk(sclk));
    // ====================================================================
    // checking and closing
    task automatic chk_word(input string what, input logic [19:0] e, input logic [19:0] s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic s);
        chk_word(what, {19'h0, e}, {19'h0, s});
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a wait that ran out is a mismatch and ends the run
    task automatic guard();
        u_host.wait_done(ok);
        if (!ok) begin
            chk_bit("done_wait", 1'b1, 1'b0);
            end_of_test();
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ====================================================================
    // one sample converted and read, its word noted before the read
    task automatic sample(input logic [15:0] v);
        @(posedge mclk_i) #2 vin = v;
        u_host.start(1);
        guard();
        exp_q.push_back({v, 4'h0});
        u_host.read();
        chk_bit("dout_pin", 1'bz, dout_pin);
    endtask
    // the oldest note is compared whenever the host finishes a read
    initial forever begin
        @(u_host.got);
        chk_word("word", exp_q.pop_front(), u_host.word);
    end
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        rst_i = 1'b1;
        cont = 1'b0;
        vin = 16'h0000;
        lfsr = 32'h4356;
        n_fail = 0;
        checks_done = 0;
        repeat (3) @(posedge mclk_i);
        #2 rst_i = 1'b0;
        // boundary codes, then random ones
        sample(16'h0000);
        sample(16'hFFFF);
        sample(16'h8000);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            sample(lfsr[15:0]);
        end
        // reread with no conversion in between
        exp_q.push_back({vin, 4'h0});
        u_host.read();
        // restart asked for at once is deferred; a stray start mid-conversion is dropped
        u_host.start(1);
        guard();
        @(posedge mclk_i) #2 vin = 16'h1234;
        u_host.start(4);
        u_host.start(3);
        guard();
        repeat (100) @(posedge mclk_i);
        chk_bit("track", 1'b1, track);
        exp_q.push_back({16'h1234, 4'h0});
        u_host.read();
        // done wired back to start: back-to-back conversions
        @(posedge mclk_i) #2 vin = 16'hC3A5;
        cont = 1'b1;
        repeat (3) guard();
        for (int i = 0; i < 400 && done_n !== 1'b1; i++) @(posedge mclk_i);
        // a rise that never came is a mismatch and closes the run
        if (done_n !== 1'b1) begin
            chk_bit("done_rise", 1'b1, 1'b0);
            end_of_test();
        end
        #2 cont = 1'b0;
        guard();
        exp_q.push_back({16'hC3A5, 4'h0});
        u_host.read();
        chk_bit("queue_empty", 1'b1, exp_q.size() == 0);
        end_of_test();
    end
endmodule
